// >>> logic/mrsc_pkg.sv
// Purpose: shared constants and types of the magnet ramp controller
// Assumes: one 25 MHz clock; values are signed Q14.50 amps or volts
// Notes: a 64-bit value is written high word to the stage, then low word
package mrsc_pkg;
  // Clock and timing
  localparam int CLK_HZ = 25_000_000;
  localparam int SEC_TIME_S = 1; // Countdown tick period, seconds
  localparam int SEC_DIV = SEC_TIME_S * CLK_HZ; // Cycles per tick
  localparam int UPD_HZ = 64; // Ramp updates per second
  localparam int UPD_SHIFT = 6; // Log2 of the update rate
  localparam int UPD_DIV = CLK_HZ / UPD_HZ; // Cycles per update

  // Value formats
  localparam int VAL_W = 64; // Full value width
  localparam int FRAC_W = 50; // Fraction bits, over 15 digits
  localparam int WORD_W = 32; // Bus word
  localparam int SEC_W = 16; // Seconds counters
  localparam int ADDR_W = 8; // Byte address
  localparam int SEG_MAX = 10; // Most ramp segments
  localparam int SEG_IDX_W = 4; // Segment index width
  localparam int SEG_STRIDE = 8; // Bytes per segment pair
  localparam int PERSIST_MA = 100; // Persistent indicator threshold
  localparam int MA_PER_A = 1000; // Milliamps per amp
  localparam int ZERO_DIV = 1000; // Zero band is full scale / 1000

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STAGE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_TARGET = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_LIMIT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_VLIMIT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_SWRATE = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_HEAT = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_COOL = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_FINE = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_SEGCNT = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_SETP_LO = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_SETP_HI = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_SEG = 8'h40;

  // Command register bits, one pulse each
  localparam int CMD_PAUSE = 0;
  localparam int CMD_RAISE = 1;
  localparam int CMD_LOWER = 2;
  localparam int CMD_DISCHARGE = 3;
  localparam int CMD_SWITCH = 4;
  localparam int CMD_ENTER = 5;
  localparam int CMD_ESCAPE = 6;
  localparam int CMD_FINE = 7;

  // Status register fields
  localparam int ST_MODE = 0;
  localparam int ST_HEAT = 3;
  localparam int ST_LED = 4;
  localparam int ST_REQ = 5;
  localparam int ST_FINE = 6;
  localparam int ST_SECS = 16;

  // Reset values of the timing registers, seconds
  localparam logic [SEC_W-1:0] HEAT_RST = 16'h0014;
  localparam logic [SEC_W-1:0] COOL_RST = 16'h0014;

  typedef logic signed [VAL_W-1:0] mrsc_val_t;
  typedef logic [SEC_W-1:0] mrsc_sec_t;

  // One amp in value units
  localparam mrsc_val_t ONE_A = 64'sh0004_0000_0000_0000;
  localparam mrsc_val_t PERSIST_THR =
    (ONE_A * mrsc_val_t'(PERSIST_MA)) / mrsc_val_t'(MA_PER_A);

  // Ramp modes, one at a time
  typedef enum logic [2:0] {
    MODE_RAMPING,
    MODE_HOLDING,
    MODE_PAUSED,
    MODE_MANUAL,
    MODE_ZEROING,
    MODE_ZERO_CUR,
    MODE_HEATING,
    MODE_COOLING
  } mrsc_mode_e;

  // Register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic wr;
    logic rd;
  } mrsc_bus_s;

  // Magnitude of a signed value
  function automatic mrsc_val_t mrsc_abs(input mrsc_val_t v);
    mrsc_abs = v[VAL_W-1] ? -v : v;
  endfunction
endpackage

// >>> logic/mrsc_sec_timer.sv
// Purpose: seconds countdown for switch heating and cooling
// Assumes: load is a one-cycle pulse
// Notes: a load restarts the count; zero seconds ends next cycle
`timescale 1ns/1ns
module mrsc_sec_timer
  import mrsc_pkg::*;
#(
  parameter int DIV = SEC_DIV // Cycles per second
)(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic load,
  input wire mrsc_sec_t secs,
  output mrsc_sec_t remain,
  output logic done
);
  if (DIV < 2) $error("DIV too small");

  // Whole timer state
  typedef struct packed {
    logic [31:0] cnt; // Cycle divider
    mrsc_sec_t left; // Seconds still to run
    logic run; // Counting
    logic done; // End pulse
  } mrsc_tmr_s;

  mrsc_tmr_s s;
  mrsc_tmr_s n;

  // Next state
  always_comb
  begin
    n = s;
    n.done = 1'b0;
    if (load)
    begin
      n.cnt = '0;
      n.left = secs;
      n.run = (secs != '0);
      n.done = (secs == '0);
    end
    else if (s.run)
    begin
      if (s.cnt == 32'(DIV - 1))
      begin
        n.cnt = '0;
        n.left = s.left - 1'b1;
        if (s.left == 16'h0001)
        begin
          n.run = 1'b0;
          n.done = 1'b1;
        end
      end
      else
        n.cnt = s.cnt + 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= n;
  end

  assign remain = s.left;
  assign done = s.done;
endmodule

// >>> logic/mrsc_seg_table.sv
// Purpose: ramp segment boundaries, rates and rate selection
// Assumes: boundaries rise with index; magnitude is unsigned current
// Notes: above the last boundary the last used rate applies
`timescale 1ns/1ns
module mrsc_seg_table
  import mrsc_pkg::*;
#(
  parameter int SEG_N = SEG_MAX // Segments held
)(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [SEG_IDX_W-1:0] idx,
  input wire logic is_rate,
  input wire mrsc_val_t wr_val,
  input wire logic [SEG_IDX_W-1:0] seg_cnt,
  input wire mrsc_val_t magnitude,
  output logic [WORD_W-1:0] rd_word,
  output mrsc_val_t rate_sel
);
  if (SEG_N < 1 || SEG_N > SEG_MAX) $error("SEG_N out of range");

  // Whole table state
  typedef struct packed {
    logic [SEG_N-1:0][VAL_W-1:0] bound; // Upper current per segment
    logic [SEG_N-1:0][VAL_W-1:0] rate; // Rate per segment
    mrsc_val_t sel; // Rate in force
  } mrsc_seg_s;

  mrsc_seg_s s;
  mrsc_seg_s n;

  // Stores writes and picks the segment rate every cycle
  always_comb
  begin
    n = s;
    if (wr_en && idx < SEG_IDX_W'(SEG_N))
    begin
      if (is_rate)
        n.rate[idx] = wr_val;
      else
        n.bound[idx] = wr_val;
    end
    // Default: last segment in use
    n.sel = s.rate[0];
    for (int i = 0; i < SEG_N; i++)
      if (SEG_IDX_W'(i) < seg_cnt)
        n.sel = s.rate[i];
    // Lowest segment whose boundary lies above the current
    for (int i = SEG_N - 1; i >= 0; i--)
      if (SEG_IDX_W'(i) < seg_cnt && magnitude < mrsc_val_t'(s.bound[i]))
        n.sel = s.rate[i];
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= n;
  end

  // Readback of the low word
  always_comb
  begin
    rd_word = '0;
    if (idx < SEG_IDX_W'(SEG_N))
      rd_word = is_rate ? s.rate[idx][WORD_W-1:0] :
        s.bound[idx][WORD_W-1:0];
  end

  assign rate_sel = s.sel;
endmodule

// >>> logic/mrsc_ramp_ctrl.sv
// Purpose: magnet current ramp sequencer and switch heater control
// Assumes: bus strobes are single cycle; inputs synchronous to clock
// Notes: setpoint moves once per update tick by rate / UPD_HZ
//
// Summary of operation
// - Up to ten segments, each own rate
// - Manual raise or lower, ends at limit
// - Auto direction from current versus target
// - Ramp/pause toggles between ramping and paused
// - Reaching target enters holding at target
// - Paused freezes output where it stopped
// - Discharge ramps to zero; near zero reported
// - No ramping while heating or cooling switch
// - Voltage limit and rates govern both modes
// - New target ramps now unless paused, heating or cooling
// - Entered values keep fifteen fractional digits
// - Fine adjust only holding; tracks segment rate
// - Fine adjust clamped to current limit
// - Fine target holds fifteen-digit resolution
// - Enter commits fine value; else restore
// - Heater state kept over power loss
// - Switch command heats, then paused
// - Persistent request only holding/paused at target
// - Request waits for enter; escape cancels
// - Enter cools switch, seconds left shown
// - Cooled: indicator on, discharge_cmd
// - Indicator needs magnet current over 100 mA
`timescale 1ns/1ns
module mrsc_ramp_ctrl
  import mrsc_pkg::*;
#(
  parameter int SEG_N = SEG_MAX, // Segments in use at most
  parameter int FULL_SCALE_A = 100, // Full-scale current, amps
  parameter int UPD_CYC = UPD_DIV, // Cycles per ramp update
  parameter int SEC_CYC = SEC_DIV // Cycles per countdown second
)(
  input wire logic clock,
  input wire logic sys_rst,
  input wire mrsc_bus_s bus,
  output logic [WORD_W-1:0] rd_data,
  input wire mrsc_val_t magnet_current,
  input wire mrsc_val_t supply_volts,
  input wire logic heater_nv,
  output mrsc_val_t setpoint,
  output logic heater_on,
  output logic persist_led,
  output mrsc_mode_e mode
);
  if (SEG_N < 1 || SEG_N > SEG_MAX) $error("SEG_N out of range");
  if (UPD_CYC < 2) $error("UPD_CYC too small");
  if (FULL_SCALE_A < 1) $error("FULL_SCALE_A too small");

  // Near-zero band for the zero current report
  localparam mrsc_val_t ZERO_THR =
    (ONE_A * mrsc_val_t'(FULL_SCALE_A)) / mrsc_val_t'(ZERO_DIV);

  // Whole controller state
  typedef struct packed {
    mrsc_mode_e mode; // Present ramp mode
    logic manual_up; // Manual direction
    logic heater; // Switch heater drive
    logic led; // Persistent indicator
    logic req; // Persistent entry awaiting enter
    logic fine; // Fine adjust session open
    logic sw_zero; // Ramp down at switch rate
    logic booted; // Heater state restored
    logic tick; // Ramp update pulse
    logic [31:0] upd_cnt; // Update divider
    mrsc_val_t setp; // Supply setpoint
    mrsc_val_t target; // Target current
    mrsc_val_t saved; // Target before fine adjust
    mrsc_val_t limit; // Current limit
    mrsc_val_t vlimit; // Voltage limit
    mrsc_val_t sw_rate; // Switch transition rate
    logic [WORD_W-1:0] stage; // High word staging
    logic [WORD_W-1:0] rdata; // Read answer
    mrsc_sec_t heat_s; // Heater on duration
    mrsc_sec_t cool_s; // Heater off duration
    logic [SEG_IDX_W-1:0] seg_cnt; // Segments in use
  } mrsc_core_s;

  mrsc_core_s s;
  mrsc_core_s n;

  logic [WORD_W-1:0] cmd; // Command pulses this cycle
  logic wr_any; // Any register write
  logic seg_hit; // Address falls in segment table
  logic [SEG_IDX_W-1:0] seg_idx; // Segment addressed
  logic [WORD_W-1:0] seg_rd; // Segment readback
  logic [WORD_W-1:0] status; // Status word
  mrsc_val_t wval; // Full written value
  mrsc_val_t rate_sel; // Segment rate in force
  mrsc_val_t rate_now; // Rate used this update
  mrsc_val_t step; // Setpoint change per update
  mrsc_val_t goal; // Where the setpoint is heading
  mrsc_val_t fine_sum; // Adjusted fine target
  mrsc_val_t mag_i; // Magnet current magnitude
  logic inhibit; // Switch transition in progress
  logic vblock; // Supply at voltage limit
  logic moving; // Setpoint may move this cycle
  logic tmr_load; // Start the seconds timer
  mrsc_sec_t tmr_secs; // Seconds to load
  mrsc_sec_t tmr_left; // Seconds remaining
  logic tmr_done; // Timer expiry pulse

  // Segment rates and boundaries
  mrsc_seg_table #(
    .SEG_N(SEG_N)
  ) u_seg (
    .clock(clock),
    .sys_rst(sys_rst),
    .wr_en(wr_any && seg_hit),
    .idx(seg_idx),
    .is_rate(bus.addr[2]),
    .wr_val(wval),
    .seg_cnt(s.seg_cnt),
    .magnitude(mrsc_abs(s.setp)),
    .rd_word(seg_rd),
    .rate_sel(rate_sel)
  );

  // Heating and cooling countdown
  mrsc_sec_timer #(
    .DIV(SEC_CYC)
  ) u_tmr (
    .clock(clock),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .secs(tmr_secs),
    .remain(tmr_left),
    .done(tmr_done)
  );

  // Bus decode
  always_comb
  begin
    wr_any = bus.wr;
    cmd = (bus.wr && bus.addr == OFF_CMD) ? bus.wdata : '0;
    seg_hit = bus.addr >= OFF_SEG &&
      bus.addr < OFF_SEG + ADDR_W'(SEG_STRIDE * SEG_MAX);
    seg_idx = SEG_IDX_W'((bus.addr - OFF_SEG) >> 3);
    wval = {s.stage, bus.wdata};
  end

  // Status word
  always_comb
  begin
    status = '0;
    status[ST_MODE +: 3] = s.mode;
    status[ST_HEAT] = s.heater;
    status[ST_LED] = s.led;
    status[ST_REQ] = s.req;
    status[ST_FINE] = s.fine;
    status[ST_SECS +: SEC_W] = tmr_left;
  end

  // Ramp step arithmetic
  always_comb
  begin
    mag_i = mrsc_abs(magnet_current);
    inhibit = s.mode == MODE_HEATING || s.mode == MODE_COOLING;
    vblock = s.vlimit != '0 && mrsc_abs(supply_volts) > s.vlimit;
    rate_now = s.sw_zero ? s.sw_rate : rate_sel;
    step = rate_now >>> UPD_SHIFT;
    // Goal per mode
    unique case (s.mode)
      MODE_MANUAL:
        goal = s.manual_up ? s.limit : -s.limit;
      MODE_ZEROING, MODE_ZERO_CUR:
        goal = '0;
      default:
        goal = s.target;
    endcase
    // Paused and switch modes never move
    moving = s.tick && !vblock && (s.mode == MODE_RAMPING ||
      s.mode == MODE_HOLDING || s.mode == MODE_MANUAL ||
      s.mode == MODE_ZEROING || s.mode == MODE_ZERO_CUR);
    // Fine target, clamped to the limit
    fine_sum = s.target + mrsc_val_t'(signed'(bus.wdata));
    if (fine_sum > s.limit)
      fine_sum = s.limit;
    else if (fine_sum < -s.limit)
      fine_sum = -s.limit;
  end

  // Next state
  always_comb
  begin
    n = s;
    n.rdata = '0;
    tmr_load = 1'b0;
    tmr_secs = s.heat_s;

    // First cycle after reset restores the heater
    if (!s.booted)
    begin
      n.booted = 1'b1;
      n.heater = heater_nv;
    end

    // Update tick divider
    n.tick = 1'b0;
    if (s.upd_cnt == 32'(UPD_CYC - 1))
    begin
      n.upd_cnt = '0;
      n.tick = 1'b1;
    end
    else
      n.upd_cnt = s.upd_cnt + 32'h0000_0001;

    // Setpoint motion toward the goal
    if (moving)
    begin
      if (s.setp < goal)
        n.setp = (goal - s.setp > step) ? s.setp + step : goal;
      else if (s.setp > goal)
        n.setp = (s.setp - goal > step) ? s.setp - step : goal;
    end
    // Arrival at target
    if (s.mode == MODE_RAMPING && n.setp == s.target)
      n.mode = MODE_HOLDING;
    // Near-zero report while discharging
    if (s.mode == MODE_ZEROING && mag_i < ZERO_THR)
      n.mode = MODE_ZERO_CUR;
    else if (s.mode == MODE_ZERO_CUR && mag_i >= ZERO_THR)
      n.mode = MODE_ZEROING;

    // Timer expiry
    if (tmr_done && s.mode == MODE_HEATING)
      n.mode = MODE_PAUSED;
    else if (tmr_done && s.mode == MODE_COOLING)
    begin
      n.led = mag_i > PERSIST_THR;
      n.sw_zero = 1'b1;
      n.mode = MODE_ZEROING;
    end

    // Any command but enter, or a target write, abandons fine adjust
    if (s.fine && ((|(cmd & ~(WORD_W'(1) << CMD_ENTER))) ||
        (wr_any && bus.addr == OFF_TARGET)))
    begin
      n.target = s.saved;
      n.fine = 1'b0;
      n.mode = MODE_RAMPING;
    end

    // Register writes
    if (wr_any)
    begin
      case (bus.addr)
        OFF_STAGE: n.stage = bus.wdata;
        OFF_TARGET:
        begin
          n.target = wval;
          if (s.mode != MODE_PAUSED && !inhibit)
            n.mode = MODE_RAMPING;
        end
        OFF_LIMIT: n.limit = wval;
        OFF_VLIMIT: n.vlimit = wval;
        OFF_SWRATE: n.sw_rate = wval;
        OFF_HEAT: n.heat_s = bus.wdata[SEC_W-1:0];
        OFF_COOL: n.cool_s = bus.wdata[SEC_W-1:0];
        OFF_SEGCNT:
          n.seg_cnt = (bus.wdata > WORD_W'(SEG_N)) ?
            SEG_IDX_W'(SEG_N) : bus.wdata[SEG_IDX_W-1:0];
        OFF_FINE:
          if (s.fine)
            n.target = fine_sum;
        default: ;
      endcase
    end

    // Operator commands, ignored during switch transitions
    if (!inhibit)
    begin
      if (cmd[CMD_PAUSE])
      begin
        if (s.mode == MODE_PAUSED)
          n.mode = MODE_RAMPING;
        else if (s.mode != MODE_HOLDING)
          n.mode = MODE_PAUSED;
      end
      if (cmd[CMD_RAISE] || cmd[CMD_LOWER])
      begin
        n.mode = MODE_MANUAL;
        n.manual_up = cmd[CMD_RAISE];
        n.sw_zero = 1'b0;
      end
      if (cmd[CMD_DISCHARGE])
      begin
        n.mode = MODE_ZEROING;
        n.sw_zero = 1'b0;
      end
      if (cmd[CMD_FINE] && s.mode == MODE_HOLDING && !s.fine)
      begin
        n.fine = 1'b1;
        n.saved = s.target;
      end
      if (cmd[CMD_SWITCH])
      begin
        if (!s.heater)
        begin
          n.heater = 1'b1;
          n.led = 1'b0;
          n.mode = MODE_HEATING;
          tmr_load = 1'b1;
          tmr_secs = s.heat_s;
        end
        else if ((s.mode == MODE_HOLDING || s.mode == MODE_PAUSED) &&
                 s.setp == s.target)
          n.req = 1'b1;
      end
      if (cmd[CMD_ENTER])
      begin
        if (s.req)
        begin
          n.req = 1'b0;
          n.heater = 1'b0;
          n.mode = MODE_COOLING;
          tmr_load = 1'b1;
          tmr_secs = s.cool_s;
        end
        else if (s.fine)
          n.fine = 1'b0;
      end
    end
    // Escape cancels a pending persistent request
    if (cmd[CMD_ESCAPE])
      n.req = 1'b0;

    // Read answer for the next cycle
    if (bus.rd)
    begin
      case (bus.addr)
        OFF_STAGE: n.rdata = s.stage;
        OFF_TARGET: n.rdata = s.target[WORD_W-1:0];
        OFF_LIMIT: n.rdata = s.limit[WORD_W-1:0];
        OFF_VLIMIT: n.rdata = s.vlimit[WORD_W-1:0];
        OFF_SWRATE: n.rdata = s.sw_rate[WORD_W-1:0];
        OFF_HEAT: n.rdata = WORD_W'(s.heat_s);
        OFF_COOL: n.rdata = WORD_W'(s.cool_s);
        OFF_FINE: n.rdata = s.saved[WORD_W-1:0];
        OFF_SEGCNT: n.rdata = WORD_W'(s.seg_cnt);
        OFF_STATUS: n.rdata = status;
        OFF_SETP_LO: n.rdata = s.setp[WORD_W-1:0];
        OFF_SETP_HI: n.rdata = s.setp[VAL_W-1:WORD_W];
        default: n.rdata = seg_hit ? seg_rd : '0;
      endcase
    end
  end

  // State register; power-up shows paused at zero
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s <= '0;
      s.mode <= MODE_PAUSED;
      s.heat_s <= HEAT_RST;
      s.cool_s <= COOL_RST;
      s.seg_cnt <= SEG_IDX_W'(SEG_N);
    end
    else
      s <= n;
  end

  // Outputs straight from state
  assign rd_data = s.rdata;
  assign setpoint = s.setp;
  assign heater_on = s.heater;
  assign persist_led = s.led;
  assign mode = s.mode;
endmodule

// >>> test/mrsc_magnet_model.sv
// Purpose: coil whose current follows the supply
// Assumes: ideal coil, one cycle lag
// Notes: heavy raises supply volts to 2 V
`timescale 1ns/1ns
module mrsc_magnet_model
  import mrsc_pkg::*;
(
  input wire logic clock,
  input wire mrsc_val_t setpoint,
  input wire logic heavy,
  output mrsc_val_t magnet_current,
  output mrsc_val_t supply_volts
);
  // Current trails the setpoint
  always_ff @(posedge clock)
  begin
    magnet_current <= setpoint;
  end
  // Two volts when stalled, else none
  assign supply_volts = heavy ? (ONE_A <<< 1) : '0;
endmodule

// >>> test/mrsc_ramp_ctrl_assertions.sv
// Purpose: port checks of the ramp controller
// Assumes: 20 s heat, 16 cycle second
// Notes: reset disables all checks
`timescale 1ns/1ns
module mrsc_chk
  import mrsc_pkg::*;
#(
  parameter int FULL_SCALE_A = 100
)(
  input wire logic clock,
  input wire logic sys_rst,
  input wire mrsc_bus_s bus,
  input wire logic [WORD_W-1:0] rd_data,
  input wire mrsc_val_t magnet_current,
  input wire mrsc_val_t supply_volts,
  input wire logic heater_nv,
  input wire mrsc_val_t setpoint,
  input wire logic heater_on,
  input wire logic persist_led,
  input wire mrsc_mode_e mode
);
  // Zero current band
  localparam mrsc_val_t BAND = (ONE_A * mrsc_val_t'(FULL_SCALE_A)) /
    mrsc_val_t'(ZERO_DIV);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Switch phase for two samples
  sequence s_inhibit;
    (mode == MODE_HEATING || mode == MODE_COOLING) ##1 $stable(mode);
  endsequence
  // Heating starts
  sequence s_heat_start;
    mode == MODE_HEATING && $changed(mode);
  endsequence
  // Fine adjust may move the output later in holding, so only arrival
  property p_hold_keep;
    $changed(mode) && mode == MODE_HOLDING && !bus.wr |=> $stable(setpoint);
  endproperty
  property p_pause_keep;
    mode == MODE_PAUSED && !bus.wr |=> $stable(setpoint);
  endproperty
  property p_inhibit;
    s_inhibit |-> $stable(setpoint);
  endproperty
  property p_heat_len;
    s_heat_start |-> ##[300:340] mode == MODE_PAUSED;
  endproperty
  property p_heat_drive;
    mode == MODE_HEATING |-> heater_on;
  endproperty
  property p_cool_entry;
    mode == MODE_COOLING && $changed(mode)
      |-> $past(heater_on) && !heater_on;
  endproperty
  property p_hold_entry;
    mode == MODE_HOLDING && $changed(mode)
      |-> $past(mode) == MODE_RAMPING;
  endproperty
  property p_zero_entry;
    mode == MODE_ZERO_CUR && $changed(mode)
      |-> mrsc_abs($past(magnet_current)) < BAND;
  endproperty
  property p_led_rise;
    $rose(persist_led) |-> mrsc_abs($past(magnet_current)) > PERSIST_THR;
  endproperty
  a_hold_keep: assert property (p_hold_keep)
    else $error("holding setpoint moved");
  a_pause_keep: assert property (p_pause_keep)
    else $error("paused setpoint moved");
  a_inhibit: assert property (p_inhibit)
    else $error("setpoint moved in switch phase");
  a_heat_len: assert property (p_heat_len)
    else $error("heating end late");
  a_heat_drive: assert property (p_heat_drive)
    else $error("heater off while heating");
  a_cool_entry: assert property (p_cool_entry)
    else $error("cooling without heater off");
  a_hold_entry: assert property (p_hold_entry)
    else $error("holding not from ramping");
  a_zero_entry: assert property (p_zero_entry)
    else $error("zero current outside band");
  a_led_rise: assert property (p_led_rise)
    else $error("indicator lit at low current");
endmodule

bind mrsc_ramp_ctrl mrsc_chk #(.FULL_SCALE_A(FULL_SCALE_A)) mrsc_chk_i (
  .clock(clock), .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data),
  .magnet_current(magnet_current), .supply_volts(supply_volts),
  .heater_nv(heater_nv), .setpoint(setpoint), .heater_on(heater_on),
  .persist_led(persist_led), .mode(mode));

// >>> test/tb_top.sv
// Purpose: bench for the ramp controller
// Assumes: 8 cycle ramp tick, 16 cycle second
// Notes: values are Q14.50 amps
`timescale 1ns/1ns
module tb_top
  import mrsc_pkg::*;
;
  localparam mrsc_val_t A1 = ONE_A; // One amp
  localparam mrsc_val_t TOP = 10 * A1; // Current limit
  localparam mrsc_val_t B0 = 4 * A1 + 5; // First segment bound
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic heater_nv = 1'b0; // Stored heater state
  logic heavy = 1'b0; // Stall the load
  mrsc_bus_s bus = '0;
  logic [WORD_W-1:0] rd_data;
  mrsc_val_t magnet_current;
  mrsc_val_t supply_volts;
  mrsc_val_t setpoint;
  logic heater_on;
  logic persist_led;
  mrsc_mode_e mode;
  logic [WORD_W-1:0] d; // Read result
  int fails = 0;
  int n_compared = 0;

  // Clock, 40 ns period
  always #20 clock = ~clock;

  mrsc_ramp_ctrl #(.UPD_CYC(8), .SEC_CYC(16)) mrsc_ramp_ctrl_i (
    .clock(clock), .sys_rst(sys_rst), .bus(bus), .rd_data(rd_data),
    .magnet_current(magnet_current), .supply_volts(supply_volts),
    .heater_nv(heater_nv), .setpoint(setpoint), .heater_on(heater_on),
    .persist_led(persist_led), .mode(mode));

  mrsc_magnet_model mrsc_magnet_model_i (
    .clock(clock), .setpoint(setpoint), .heavy(heavy),
    .magnet_current(magnet_current), .supply_volts(supply_volts));

  task automatic print_verdict();
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Counts one comparison
  task automatic chk(input string what, input logic [63:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  // One write cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clock);
    bus <= '0;
  endtask

  // Stage high, then low
  task automatic wr64(input logic [7:0] a, input mrsc_val_t v);
    wr(OFF_STAGE, v[63:32]);
    wr(a, v[31:0]);
  endtask

  task automatic cmd(input int b);
    wr(OFF_CMD, 32'h1 << b);
  endtask

  // Data stand the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    @(negedge clock);
    v = rd_data;
  endtask

  // Waits for mode m at g, checking steps
  task automatic ramp_until(input mrsc_mode_e m, input mrsc_val_t g,
    input mrsc_val_t sw);
    mrsc_val_t p, st, dv;
    p = setpoint;
    for (int i = 0; i < 2000; i++)
    begin
      @(negedge clock);
      if (setpoint !== p && setpoint !== g)
      begin
        st = sw;
        if (sw == 0)
          st = (p < B0 && p > -B0) ? A1 : 2 * A1;
        dv = setpoint - p;
        chk("ramp step", st, mrsc_abs(dv));
      end
      p = setpoint;
      if (mode === m && setpoint === g)
        return;
    end
    fails++;
    $display("mismatch wait expected %0d seen %0d", m, mode);
    print_verdict();
  endtask

  // Reset values, unmapped read, segments
  task automatic t_setup();
    chk("reset mode", MODE_PAUSED, mode);
    rd(OFF_HEAT, d);
    chk("heat secs", 32'h14, d);
    rd(OFF_COOL, d);
    chk("cool secs", 32'h14, d);
    rd(8'h3c, d);
    chk("unmapped", 32'h0, d);
    wr64(OFF_SEG, B0);
    wr64(OFF_SEG + 8'h04, 64 * A1);
    wr64(OFF_SEG + 8'h08, 100 * A1);
    wr64(OFF_SEG + 8'h0c, 128 * A1);
    wr(OFF_SEGCNT, 32'h2);
    wr64(OFF_LIMIT, TOP);
    wr64(OFF_SWRATE, 64 * A1);
    wr64(OFF_VLIMIT, A1);
    rd(OFF_SEG, d);
    chk("kept fraction", 32'h5, d);
  endtask

  // Paused target, then up and down
  task automatic t_auto();
    wr64(OFF_TARGET, 6 * A1);
    repeat (20) @(negedge clock);
    chk("paused target", 0, setpoint);
    cmd(CMD_PAUSE);
    ramp_until(MODE_HOLDING, 6 * A1, 0);
    wr64(OFF_TARGET, A1);
    ramp_until(MODE_HOLDING, A1, 0);
  endtask

  // Pause in mid ramp and resume
  task automatic t_pause();
    mrsc_val_t f;
    wr64(OFF_TARGET, 6 * A1);
    repeat (12) @(posedge clock);
    cmd(CMD_PAUSE);
    @(negedge clock);
    f = setpoint;
    repeat (40) @(negedge clock);
    chk("frozen", f, setpoint);
    chk("pause mode", MODE_PAUSED, mode);
    cmd(CMD_PAUSE);
    ramp_until(MODE_HOLDING, 6 * A1, 0);
  endtask

  // Manual travel after a voltage stall
  task automatic t_manual();
    @(posedge clock) heavy <= 1'b1;
    cmd(CMD_RAISE);
    repeat (40) @(negedge clock);
    chk("volt stall", 6 * A1, setpoint);
    chk("manual mode", MODE_MANUAL, mode);
    @(posedge clock) heavy <= 1'b0;
    ramp_until(MODE_MANUAL, TOP, 0);
    cmd(CMD_LOWER);
    ramp_until(MODE_MANUAL, -TOP, 0);
  endtask

  task automatic t_zero();
    cmd(CMD_DISCHARGE);
    @(negedge clock);
    chk("zeroing", MODE_ZEROING, mode);
    ramp_until(MODE_ZERO_CUR, 0, 0);
  endtask

  // Fine adjust: clamp, track, restore, commit
  task automatic t_fine();
    cmd(CMD_PAUSE);
    wr64(OFF_TARGET, TOP);
    cmd(CMD_PAUSE);
    ramp_until(MODE_HOLDING, TOP, 0);
    cmd(CMD_FINE);
    wr(OFF_FINE, 32'h3e8);
    repeat (24) @(negedge clock);
    chk("fine clamp", TOP, setpoint);
    cmd(CMD_ENTER);
    cmd(CMD_FINE);
    wr(OFF_FINE, 32'hffff_fffb);
    repeat (24) @(negedge clock);
    chk("fine track", TOP - 5, setpoint);
    cmd(CMD_ESCAPE);
    ramp_until(MODE_HOLDING, TOP, 0);
    cmd(CMD_FINE);
    wr(OFF_FINE, 32'hffff_fffb);
    cmd(CMD_ENTER);
    rd(OFF_TARGET, d);
    chk("fine commit", 32'hffff_fffb, d);
    ramp_until(MODE_HOLDING, TOP - 5, 0);
  endtask

  // Heat, cancel, then cool to persistent
  task automatic t_switch();
    cmd(CMD_SWITCH);
    @(negedge clock);
    chk("heating", MODE_HEATING, mode);
    chk("heater on", 1, heater_on);
    ramp_until(MODE_PAUSED, TOP - 5, 0);
    cmd(CMD_SWITCH);
    rd(OFF_STATUS, d);
    chk("request", 1, d[ST_REQ]);
    cmd(CMD_ESCAPE);
    rd(OFF_STATUS, d);
    chk("cancel", 0, d[ST_REQ]);
    cmd(CMD_SWITCH);
    cmd(CMD_ENTER);
    rd(OFF_STATUS, d);
    chk("cooling", MODE_COOLING, d[2:0]);
    chk("seconds", 32'h14, d[31:16]);
    chk("heater off", 0, heater_on);
    ramp_until(MODE_ZERO_CUR, 0, A1);
    chk("led", 1, persist_led);
  endtask

  // Heater state restored after reset
  task automatic t_restore();
    @(posedge clock);
    heater_nv <= 1'b1;
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    chk("heater restore", 1, heater_on);
  endtask

  initial
  begin
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clock);
    t_setup();
    t_auto();
    t_pause();
    t_manual();
    t_zero();
    t_fine();
    t_switch();
    t_restore();
    print_verdict();
  end
endmodule
